// File: verilog/opm_defs.svh
`ifndef OPM_DEFS_SVH
`define OPM_DEFS_SVH
// Temperature thresholds in degrees C, sensor codes are integer degrees.
`define OPM_TEMP_WARN_SET   8'd120
`define OPM_TEMP_WARN_CLR   8'd117
`define OPM_TEMP_FAULT_SET  8'd120
`define OPM_TEMP_RESTART    8'd110
// Fault latch configuration field positions.
`define OPM_FLC_TRACK_EN    7
`define OPM_FLC_TRACK_LAT   5
`define OPM_FLC_HEAT_LAT    4
`define OPM_FLC_OC_LAT      3
`define OPM_FLC_UV_LAT      2
`define OPM_FLC_OV_LAT      1
`define OPM_FLC_RESET       8'h83
// Fault spread configuration field positions.
`define OPM_FSC_TEMP_MSG    7
`define OPM_FSC_PG_MSG      6
`define OPM_FSC_TRACK_PROP  5
`define OPM_FSC_HEAT_PROP   4
`define OPM_FSC_OC_PROP     3
`define OPM_FSC_UV_PROP     2
`define OPM_FSC_RESET       8'h3C
// Current limit configuration temperature compensation bit.
`define OPM_CLC_TCOMP_EN    4
// Protection flag word bit positions, active low flags.
`define OPM_FLG_TEMP        0
`define OPM_FLG_PG          1
`define OPM_FLG_OC          2
`define OPM_FLG_UV          3
`define OPM_FLG_HEAT        4
`define OPM_FLG_TRACK       5
`define OPM_FLG_OV          6
`define OPM_FLG_RESET       7'h7F
// Retry interval 130 ms at 100 MHz.
`define OPM_RETRY_MS        130
`define OPM_CLK_MHZ         100
`define OPM_RETRY_CYC       (`OPM_RETRY_MS * 1000 * `OPM_CLK_MHZ)
`endif

// File: verilog/opm_pkg.sv
package opm_pkg;
	typedef enum logic [3:0] {
		OPM_OFF  = 4'b0001,
		OPM_RUN  = 4'b0010,
		OPM_TRIP = 4'b0100,
		OPM_WAIT = 4'b1000
	} opm_state_type;
	typedef enum logic [1:0] {
		OPM_SD_NONE    = 2'b00,
		OPM_SD_RAMPED  = 2'b01,
		OPM_SD_FAST    = 2'b10,
		OPM_SD_CROWBAR = 2'b11
	} opm_shutdown_type;
endpackage : opm_pkg

// File: verilog/opm_output_protection_manager.sv
`timescale 1ns/1ps
`include "opm_defs.svh"
module opm_output_protection_manager #(
	parameter int unsigned RETRY_CYC = `OPM_RETRY_CYC
) (
	// Clock and reset.
	input  wire logic                      clk_sys,
	input  wire logic                      rst_b,
	// Configuration.
	input  wire logic [7:0]                fault_latch_config,
	input  wire logic [7:0]                fault_spread_config,
	input  wire logic [7:0]                current_limit_config,
	// Converter status and commands.
	input  wire logic                      turn_on_cmd,
	input  wire logic                      steady_state,
	input  wire logic                      ramping_up,
	input  wire logic                      flag_clear,
	// Analog comparators, asynchronous to the clock.
	input  wire logic                      above_prebias_cmp,
	input  wire logic                      pg_high_cmp,
	input  wire logic                      pg_low_cmp,
	input  wire logic                      uv_cmp,
	input  wire logic                      ov_cmp,
	input  wire logic                      track_err_cmp,
	input  wire logic [7:0]                temp_deg,
	// Good output pin, open drain.
	input  wire logic                      good_output_pin_in,
	output logic                           good_output_pin_out,
	output logic                           good_output_pin_oe_b,
	// Group fault line, open drain.
	output logic                           group_fault_out,
	output logic                           group_fault_oe_b,
	// Power stage control and reporting.
	output logic                           output_enable,
	output opm_pkg::opm_shutdown_type      shutdown_style,
	output logic                           tcomp_enable,
	output logic                           power_manager_msg,
	output logic [6:0]                     protection_flag_word
);
	import opm_pkg::*;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [6:0] cmp_s1_r;
	logic [6:0] cmp_s2_r;
	logic [7:0] temp_s1_r;
	logic [7:0] temp_s2_r;
	logic       pin_s1_r;
	logic       pin_s2_r;

	// Two stages so no decision sees a metastable level; the multi-bit
	// temperature code is assumed to change slowly relative to the clock.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_s1_r  <= 7'h00;
			cmp_s2_r  <= 7'h00;
			temp_s1_r <= 8'h00;
			temp_s2_r <= 8'h00;
			pin_s1_r  <= 1'b1;
			pin_s2_r  <= 1'b1;
		end else begin
			cmp_s1_r  <= {above_prebias_cmp, pg_high_cmp, pg_low_cmp, uv_cmp,
				ov_cmp, track_err_cmp, 1'b0};
			cmp_s2_r  <= cmp_s1_r;
			temp_s1_r <= temp_deg;
			temp_s2_r <= temp_s1_r;
			pin_s1_r  <= good_output_pin_in;
			pin_s2_r  <= pin_s1_r;
		end
	end

	logic above_pb;
	logic pg_hi;
	logic pg_lo;
	logic uv_s;
	logic ov_s;
	logic trk_s;
	// Comparator thresholds (110%, 90/95%, 110-130% clamped to 1.0V) are
	// set in the analog front end from the protection configuration.
	assign above_pb = cmp_s2_r[6];
	assign pg_hi    = cmp_s2_r[5];
	assign pg_lo    = cmp_s2_r[4];
	assign uv_s     = cmp_s2_r[3];
	assign ov_s     = cmp_s2_r[2];
	assign trk_s    = cmp_s2_r[1];

	// Compensation is a pass-through to the current limit.
	assign tcomp_enable = current_limit_config[`OPM_CLC_TCOMP_EN];

	// ****************************************************************
	// Warnings
	// ****************************************************************
	logic temp_warn_r;
	logic pg_warn_r;
	logic in_window;
	logic [1:0] steady_hist_r;
	logic [1:0] oe_hist_r;
	logic settled;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			temp_warn_r <= 1'b0;
		end else if (temp_s2_r > `OPM_TEMP_WARN_SET) begin
			temp_warn_r <= 1'b1;
		end else if (temp_s2_r < `OPM_TEMP_WARN_CLR) begin
			temp_warn_r <= 1'b0;
		end
	end

	assign in_window = !pg_hi && !pg_lo;
	assign settled   = steady_state && steady_hist_r == 2'h3;

	// Pin low outside steady state; an outside low counts once our release is seen.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pg_warn_r     <= 1'b0;
			steady_hist_r <= 2'h0;
			oe_hist_r     <= 2'h0;
		end else begin
			steady_hist_r <= {steady_hist_r[0], steady_state};
			oe_hist_r     <= {oe_hist_r[0], good_output_pin_oe_b};
			pg_warn_r     <= settled && (!in_window
				|| (oe_hist_r == 2'h3 && !pin_s2_r));
		end
	end

	assign good_output_pin_out  = 1'b0;
	// Release only once settled, so stale window results never let the pin float high.
	assign good_output_pin_oe_b = settled && in_window;

	// ****************************************************************
	// Faults and error
	// ****************************************************************
	opm_state_type state_r;
	opm_state_type state_nxt;
	logic [6:0]    flags_r;
	logic          oc_trip;
	logic          uv_trip;
	logic          heat_trip;
	logic          trk_trip;
	logic          ov_trip;
	logic          any_trip;
	logic          latched;
	logic          cond_gone;
	logic [31:0]   retry_cnt_r;
	logic          retry_done;
	logic          on_d_r;

	assign oc_trip   = state_r == OPM_RUN && above_pb && uv_s && !steady_state;
	assign uv_trip   = state_r == OPM_RUN && steady_state && uv_s && !oc_trip;
	assign heat_trip = state_r == OPM_RUN && temp_s2_r > `OPM_TEMP_FAULT_SET;
	assign trk_trip  = state_r == OPM_RUN && ramping_up && trk_s
		&& fault_latch_config[`OPM_FLC_TRACK_EN];
	assign ov_trip   = state_r == OPM_RUN && above_pb && ov_s;
	assign any_trip  = oc_trip || uv_trip || heat_trip || trk_trip || ov_trip;

	// Hardware trips win over a software clear in the same cycle.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flags_r <= `OPM_FLG_RESET;
		end else begin
			flags_r[`OPM_FLG_OC]    <= !oc_trip && (flags_r[`OPM_FLG_OC] || flag_clear);
			flags_r[`OPM_FLG_UV]    <= !uv_trip && (flags_r[`OPM_FLG_UV] || flag_clear);
			flags_r[`OPM_FLG_HEAT]  <= !heat_trip && (flags_r[`OPM_FLG_HEAT] || flag_clear);
			flags_r[`OPM_FLG_TRACK] <= !trk_trip && (flags_r[`OPM_FLG_TRACK] || flag_clear);
			flags_r[`OPM_FLG_OV]    <= !ov_trip && (flags_r[`OPM_FLG_OV] || flag_clear);
			flags_r[`OPM_FLG_TEMP]  <= !temp_warn_r;
			flags_r[`OPM_FLG_PG]    <= !pg_warn_r;
		end
	end
	assign protection_flag_word = flags_r;

	// Latching if any tripped fault is configured so.
	assign latched = (!flags_r[`OPM_FLG_OC] && fault_latch_config[`OPM_FLC_OC_LAT])
		|| (!flags_r[`OPM_FLG_UV] && fault_latch_config[`OPM_FLC_UV_LAT])
		|| (!flags_r[`OPM_FLG_HEAT] && fault_latch_config[`OPM_FLC_HEAT_LAT])
		|| (!flags_r[`OPM_FLG_TRACK] && fault_latch_config[`OPM_FLC_TRACK_LAT])
		|| (!flags_r[`OPM_FLG_OV] && fault_latch_config[`OPM_FLC_OV_LAT]);
	// Heat condition counts as gone only below the restart level.
	assign cond_gone  = (temp_s2_r < `OPM_TEMP_RESTART) && !ov_s;
	assign retry_done = retry_cnt_r >= RETRY_CYC;

	// ****************************************************************
	// Turn-on and retry sequencing
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			OPM_OFF: begin
				if (turn_on_cmd && !on_d_r) begin
					state_nxt = OPM_RUN;
				end
			end
			OPM_RUN: begin
				if (!turn_on_cmd) begin
					state_nxt = OPM_OFF;
				end else if (any_trip) begin
					state_nxt = OPM_TRIP;
				end
			end
			OPM_TRIP: begin
				state_nxt = OPM_WAIT;
			end
			OPM_WAIT: begin
				if (!turn_on_cmd) begin
					state_nxt = OPM_OFF;
				end else if (retry_done && cond_gone && (!latched || flag_clear)) begin
					state_nxt = OPM_RUN;
				end
			end
			default: begin
				state_nxt = OPM_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= OPM_OFF;
			on_d_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			on_d_r  <= turn_on_cmd && state_r != OPM_OFF;
		end
	end

	// Hiccup timer runs only while waiting after a trip.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			retry_cnt_r <= 32'h0000_0000;
		end else if (state_r != OPM_WAIT) begin
			retry_cnt_r <= 32'h0000_0000;
		end else if (!retry_done) begin
			retry_cnt_r <= retry_cnt_r + 32'h0000_0001;
		end
	end

	// ****************************************************************
	// Outputs toward power stage and manager
	// ****************************************************************
	opm_shutdown_type style_r;
	logic             prop_r;
	logic             msg_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			style_r <= OPM_SD_NONE;
		end else if (state_r == OPM_RUN && any_trip) begin
			if (ov_trip)                  style_r <= OPM_SD_CROWBAR;
			else if (oc_trip || trk_trip) style_r <= OPM_SD_FAST;
			else                          style_r <= OPM_SD_RAMPED;
		end else if (state_r == OPM_RUN) begin
			style_r <= OPM_SD_NONE;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prop_r <= 1'b0;
			msg_r  <= 1'b0;
		end else begin
			prop_r <= (!flags_r[`OPM_FLG_TRACK] && fault_spread_config[`OPM_FSC_TRACK_PROP])
				|| (!flags_r[`OPM_FLG_HEAT] && fault_spread_config[`OPM_FSC_HEAT_PROP])
				|| (!flags_r[`OPM_FLG_OC] && fault_spread_config[`OPM_FSC_OC_PROP])
				|| (!flags_r[`OPM_FLG_UV] && fault_spread_config[`OPM_FSC_UV_PROP])
				|| !flags_r[`OPM_FLG_OV];
			msg_r  <= (temp_warn_r && fault_spread_config[`OPM_FSC_TEMP_MSG])
				|| (pg_warn_r && fault_spread_config[`OPM_FSC_PG_MSG]);
		end
	end

	// Warnings feed only flags and messages, never output_enable.
	assign output_enable     = state_r == OPM_RUN;
	assign shutdown_style    = style_r;
	assign group_fault_out   = 1'b0;
	assign group_fault_oe_b  = !prop_r;
	assign power_manager_msg = msg_r;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_trip;
		state_r == OPM_RUN && any_trip;
	endsequence
	sequence s_off2;
		!output_enable [*2];
	endsequence

	AST_TRIP_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_trip |=> s_off2) else $error("Output stayed on after trip.");
	AST_OV_CROWBAR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state_r == OPM_RUN && ov_trip |=> shutdown_style == OPM_SD_CROWBAR)
		else $error("Over-voltage did not select crowbar.");
	AST_OV_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ov_trip |=> !protection_flag_word[`OPM_FLG_OV]) else $error("OV flag not set.");
	AST_TEMP_WARN: assert property (@(posedge clk_sys) disable iff (!rst_b)
		temp_s2_r > `OPM_TEMP_WARN_SET |=> ##1 !protection_flag_word[`OPM_FLG_TEMP])
		else $error("Temp warning flag missing.");
	AST_TEMP_HYST: assert property (@(posedge clk_sys) disable iff (!rst_b)
		temp_warn_r && temp_s2_r >= `OPM_TEMP_WARN_CLR |=> temp_warn_r)
		else $error("Temp warning released early.");
	AST_WARN_NO_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state_r == OPM_RUN && !any_trip && turn_on_cmd |=> output_enable)
		else $error("Output went off without fault.");
	AST_PG_TRANSIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!steady_state |-> !good_output_pin_oe_b) else $error("Pin released in transition.");
	AST_RETRY_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state_r == OPM_WAIT && !retry_done |=> state_r != OPM_RUN)
		else $error("Restart before retry interval.");
endmodule : opm_output_protection_manager

// File: sim/opm_far_side_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Far side: pulled-up open-drain lines and an outside pull-down.
// ****************************************************************
module opm_far_side_model (
	// Design side of the two open-drain lines.
	input  wire logic good_output_pin_out,
	input  wire logic good_output_pin_oe_b,
	input  wire logic group_fault_out,
	input  wire logic group_fault_oe_b,
	// Outside circuit that may hold the good pin low.
	input  wire logic ext_pull_low,
	// Resolved wire levels, seen by the design and the power manager.
	output logic      good_pin_level,
	output logic      group_line_level
);
	// Both lines rest high through pull-ups, so any low driver wins the wire.
	assign good_pin_level   = (good_output_pin_oe_b | good_output_pin_out) & ~ext_pull_low;
	assign group_line_level = group_fault_oe_b | group_fault_out;
endmodule : opm_far_side_model

// File: sim/opm_output_protection_manager_bench.sv
`timescale 1ns/1ps
`include "opm_defs.svh"
`define CHK(g, e) begin \
	checks++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("[ERR] t=%0t got %h exp %h", $time, g, e); \
	end \
end
// ****************************************************************
// Protection manager bench, driven on the falling clock edge.
// ****************************************************************
module opm_output_protection_manager_bench;
	import opm_pkg::*;
	localparam int unsigned RETRY = 50;
	// Stimulus, all set at time zero.
	logic             clk_sys = 1'b0;
	logic             rst_b = 1'b0;
	logic [7:0]       fault_latch_config = 8'h80;
	logic [7:0]       fault_spread_config = 8'hC4;
	logic [7:0]       current_limit_config = 8'h10;
	logic             turn_on_cmd = 1'b0;
	logic             steady_state = 1'b0;
	logic             ramping_up = 1'b0;
	logic             flag_clear = 1'b0;
	logic             above_prebias_cmp = 1'b1;
	logic             pg_high_cmp = 1'b0;
	logic             pg_low_cmp = 1'b0;
	logic             uv_cmp = 1'b0;
	logic             ov_cmp = 1'b0;
	logic             track_err_cmp = 1'b0;
	logic [7:0]       temp_deg = 8'h19;
	logic             ext_pull_low = 1'b0;
	// Observed outputs and wire levels.
	logic             good_pin_level, group_line_level, good_output_pin_out;
	logic             good_output_pin_oe_b, group_fault_out, group_fault_oe_b;
	logic             output_enable, tcomp_enable, power_manager_msg;
	opm_shutdown_type shutdown_style;
	logic [6:0]       protection_flag_word;
	int               checks = 0;
	int               n_mismatch = 0;

	// Clock at 100 MHz.
	always #5 clk_sys = ~clk_sys;

	// Retry interval shortened so a hiccup takes tens of cycles.
	opm_output_protection_manager #(.RETRY_CYC(RETRY)) opm_output_protection_manager_inst (
		.clk_sys, .rst_b, .fault_latch_config, .fault_spread_config, .current_limit_config,
		.turn_on_cmd, .steady_state, .ramping_up, .flag_clear, .above_prebias_cmp,
		.pg_high_cmp, .pg_low_cmp, .uv_cmp, .ov_cmp, .track_err_cmp, .temp_deg,
		.good_output_pin_in(good_pin_level), .good_output_pin_out, .good_output_pin_oe_b,
		.group_fault_out, .group_fault_oe_b, .output_enable, .shutdown_style,
		.tcomp_enable, .power_manager_msg, .protection_flag_word);

	opm_far_side_model opm_far_side_model_inst (
		.good_output_pin_out, .good_output_pin_oe_b, .group_fault_out,
		.group_fault_oe_b, .ext_pull_low, .good_pin_level, .group_line_level);

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	task automatic final_report();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	// Bounded wait for the output enable; a hang ends the run.
	task automatic wait_oe(input logic e, input int lim);
		int i;
		i = 0;
		while (output_enable !== e && i < lim) begin
			cyc(1);
			i++;
		end
		`CHK(output_enable, e)
		if (output_enable !== e) final_report();
	endtask : wait_oe

	// A trip must land within ten cycles with its style and flag.
	task automatic trip(input opm_shutdown_type st, input int fb);
		wait_oe(1'b0, 10);
		`CHK(shutdown_style, st)
		`CHK(protection_flag_word[fb], 1'b0)
	endtask : trip

	task automatic clear_flags();
		flag_clear = 1'b1;
		cyc(1);
		flag_clear = 1'b0;
		cyc(1);
		`CHK(protection_flag_word, `OPM_FLG_RESET)
	endtask : clear_flags

	task automatic t_reset();
		`CHK(protection_flag_word, `OPM_FLG_RESET)
		`CHK(output_enable, 1'b0)
		`CHK(group_fault_oe_b, 1'b1)
		`CHK(tcomp_enable, 1'b1)
		current_limit_config = 8'h00;
		cyc(1);
		`CHK(tcomp_enable, 1'b0)
		turn_on_cmd = 1'b1;
		wait_oe(1'b1, 5);
	endtask : t_reset

	task automatic t_pg();
		steady_state = 1'b1;
		cyc(4);
		`CHK(good_pin_level, 1'b1)
		steady_state = 1'b0;
		cyc(4);
		`CHK(good_pin_level, 1'b0)
		steady_state = 1'b1;
		pg_low_cmp = 1'b1;
		cyc(4);
		`CHK(good_pin_level, 1'b0)
		`CHK(protection_flag_word[`OPM_FLG_PG], 1'b0)
		`CHK(power_manager_msg, 1'b1)
		`CHK(output_enable, 1'b1)
		pg_low_cmp = 1'b0;
		pg_high_cmp = 1'b1;
		fault_spread_config = 8'h84;
		cyc(4);
		`CHK(good_pin_level, 1'b0)
		`CHK(power_manager_msg, 1'b0)
		pg_high_cmp = 1'b0;
		cyc(4);
		`CHK(good_pin_level, 1'b1)
		`CHK(protection_flag_word[`OPM_FLG_PG], 1'b1)
		ext_pull_low = 1'b1;
		cyc(4);
		`CHK(protection_flag_word[`OPM_FLG_PG], 1'b0)
		ext_pull_low = 1'b0;
		fault_spread_config = 8'hC4;
		cyc(4);
	endtask : t_pg

	task automatic t_uv();
		uv_cmp = 1'b1;
		trip(OPM_SD_RAMPED, `OPM_FLG_UV);
		cyc(1);
		`CHK(group_line_level, 1'b0)
		uv_cmp = 1'b0;
		cyc(30);
		`CHK(output_enable, 1'b0)
		wait_oe(1'b1, 60);
		clear_flags();
	endtask : t_uv

	task automatic t_latch();
		fault_latch_config = 8'h84;
		uv_cmp = 1'b1;
		trip(OPM_SD_RAMPED, `OPM_FLG_UV);
		uv_cmp = 1'b0;
		cyc(RETRY + 20);
		`CHK(output_enable, 1'b0)
		clear_flags();
		wait_oe(1'b1, RETRY + 20);
		fault_latch_config = 8'h80;
	endtask : t_latch

	task automatic t_fast();
		steady_state = 1'b0;
		above_prebias_cmp = 1'b0;
		uv_cmp = 1'b1;
		cyc(6);
		`CHK(output_enable, 1'b1)
		above_prebias_cmp = 1'b1;
		trip(OPM_SD_FAST, `OPM_FLG_OC);
		`CHK(group_line_level, 1'b1)
		uv_cmp = 1'b0;
		wait_oe(1'b1, RETRY + 20);
		clear_flags();
		ov_cmp = 1'b1;
		trip(OPM_SD_CROWBAR, `OPM_FLG_OV);
		cyc(1);
		`CHK(group_line_level, 1'b0)
		ov_cmp = 1'b0;
		wait_oe(1'b1, RETRY + 20);
		clear_flags();
		fault_latch_config = 8'h00;
		ramping_up = 1'b1;
		track_err_cmp = 1'b1;
		cyc(6);
		`CHK(output_enable, 1'b1)
		fault_latch_config = 8'h80;
		trip(OPM_SD_FAST, `OPM_FLG_TRACK);
		track_err_cmp = 1'b0;
		ramping_up = 1'b0;
		wait_oe(1'b1, RETRY + 20);
		clear_flags();
	endtask : t_fast

	task automatic t_heat();
		temp_deg = 8'd121;
		trip(OPM_SD_RAMPED, `OPM_FLG_HEAT);
		cyc(1);
		`CHK(protection_flag_word[`OPM_FLG_TEMP], 1'b0)
		`CHK(power_manager_msg, 1'b1)
		temp_deg = 8'd118;
		cyc(4);
		`CHK(protection_flag_word[`OPM_FLG_TEMP], 1'b0)
		temp_deg = 8'd115;
		cyc(RETRY + 20);
		`CHK(protection_flag_word[`OPM_FLG_TEMP], 1'b1)
		`CHK(output_enable, 1'b0)
		temp_deg = 8'd100;
		wait_oe(1'b1, 10);
		clear_flags();
	endtask : t_heat

	// Main sequence: reset for 20 cycles, then each scenario in turn.
	initial begin
		repeat (20) @(posedge clk_sys);
		cyc(1);
		rst_b = 1'b1;
		cyc(2);
		t_reset();
		t_pg();
		t_uv();
		t_latch();
		t_fast();
		t_heat();
		final_report();
	end
endmodule : opm_output_protection_manager_bench
